// ===== pcr_bank.sv
/*
  pcr_bank: register bank for device reset, identity, revision, pll ratio, pre-scaler
  and transmitted validity override.
  assumes: a control interface decoder on clk_in presents one-cycle read and write strobes
  with an 8-bit address and data; clk_in is the oscillator clock seen by the pll input.
*/
// Summary of operation
// RULE_01 - any write to address 0x00 resets the whole device whatever data is written.
// RULE_02 - reading 0x00 returns the low identity byte and 0x01 the high byte, both fixed.
// RULE_03 - the 22-bit pll fraction is built from 0x03 (7:0), 0x04 (15:8) and 0x05 bits 5:0 (21:16).
// RULE_04 - the pll integer ratio is bits 3:0 of 0x06, resetting to 0111, and joins the fraction.
// RULE_05 - software should keep the integer ratio between 5 and 13, as near 8 as possible.
// RULE_06 - software must load receiver-specific ratio values while the s/pdif receiver is used.
// RULE_07 - bit 4 of 0x06 halves the oscillator clock before the pll when set.
// RULE_08 - with override clear the sent validity is 0 from the audio port or the received one from rx.
// RULE_09 - with override set, bits 5 and 6 of 0x06 are sent as subframe 0 and 1 validity.
// RULE_10 - a mode bit picks integer operation that ignores the fraction, or fractional operation.
// RULE_11 - the write-triggered reset returns every writable field to default, identity untouched.
`timescale 1ns/10ps
module pcr_bank #(
  parameter logic [15:0] ID_CODE = 16'h3c5a, // arbitrary value
  parameter logic [3:0] REVISION = 4'h1 // arbitrary value
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register port
  input wire pcr_pkg::pcr_req_t req_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // device reset
  output logic device_reset_out,
  // pll control
  output pcr_pkg::pcr_ratio_t pll_ratio_out,
  output logic pll_input_halver_out,
  output logic pll_ref_en_out,
  // s/pdif transmitter validity
  input wire logic tx_src_is_rx_in,
  input wire logic [1:0] rx_validity_in,
  output logic [1:0] tx_validity_out
);
  import pcr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pcr_regs_t regs;
    pcr_ratio_t ratio;
    logic [7:0] rd_data;
    logic rd_valid;
    logic dev_rst;
    logic halver_phase;
  } pcr_state_t;

  pcr_state_t s_q;
  pcr_state_t s_d;
  pcr_val_cfg_t val_cfg;

  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    case (addr)
      PCR_ADDR_RESET_ID_LOW: read_mux = ID_CODE[7:0]; // RULE_02
      PCR_ADDR_ID_HIGH: read_mux = ID_CODE[15:8]; // RULE_02
      PCR_ADDR_REVISION: read_mux = {4'h0, REVISION};
      // pll registers are write-only; unmapped and write-only reads give zero
      default: read_mux = PCR_READ_ZERO;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rd_valid = req_in.rd_en;
    s_d.dev_rst = 1'b0;
    if (req_in.rd_en) begin
      s_d.rd_data = read_mux(req_in.addr);
    end
    if (req_in.wr_en) begin
      case (req_in.addr)
        PCR_ADDR_RESET_ID_LOW: begin
          s_d.dev_rst = 1'b1; // RULE_01
          s_d.regs = PCR_REGS_RESET; // RULE_11
        end
        PCR_ADDR_FRAC_LOW: begin
          s_d.regs.frac[7:0] = req_in.wdata; // RULE_03
        end
        PCR_ADDR_FRAC_MID: begin
          s_d.regs.frac[15:8] = req_in.wdata; // RULE_03
        end
        PCR_ADDR_FRAC_HIGH: begin
          s_d.regs.frac[21:16] = req_in.wdata[PCR_FRAC_HIGH_MSB:0]; // RULE_03
        end
        PCR_ADDR_INT_VALIDITY: begin
          s_d.regs.integ = req_in.wdata[PCR_INT_MSB:0]; // RULE_04
          s_d.regs.halver = req_in.wdata[PCR_HALVER_BIT]; // RULE_07
          s_d.regs.val_sf = {req_in.wdata[PCR_VAL_SF1_BIT], req_in.wdata[PCR_VAL_SF0_BIT]}; // RULE_09
          s_d.regs.val_ovr = req_in.wdata[PCR_VAL_OVR_BIT]; // RULE_09
        end
        PCR_ADDR_PLL_MODE: begin
          s_d.regs.frac_mode = req_in.wdata[PCR_FRAC_MODE_BIT]; // RULE_10
        end
        default: begin
          // id, revision and unmapped writes are ignored
        end
      endcase
    end
    // ratio follows the registers one cycle later so the pll sees a glitch-free word
    s_d.ratio.integ = s_q.regs.integ; // RULE_04
    s_d.ratio.frac_mode = s_q.regs.frac_mode;
    s_d.ratio.frac = s_q.regs.frac_mode ? s_q.regs.frac : 22'h0; // RULE_10
    // phase only toggles while halving, so switching the halver off restarts cleanly
    s_d.halver_phase = s_q.regs.halver ? ~s_q.halver_phase : 1'b0; // RULE_07
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q.regs <= PCR_REGS_RESET;
      s_q.ratio <= '{frac: {PCR_RST_FRAC_HIGH, PCR_RST_FRAC_MID, PCR_RST_FRAC_LOW},
                     integ: PCR_RST_INT, frac_mode: PCR_RST_FRAC_MODE};
      s_q.rd_data <= PCR_READ_ZERO;
      s_q.rd_valid <= 1'b0;
      s_q.dev_rst <= 1'b0;
      s_q.halver_phase <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data_out = s_q.rd_data;
  assign rd_valid_out = s_q.rd_valid;
  assign device_reset_out = s_q.dev_rst; // RULE_01
  assign pll_ratio_out = s_q.ratio;
  assign pll_input_halver_out = s_q.regs.halver;
  // pll reference advances every cycle, or every second cycle when halving
  assign pll_ref_en_out = ~s_q.regs.halver | s_q.halver_phase; // RULE_07

  assign val_cfg = '{override: s_q.regs.val_ovr, sf: s_q.regs.val_sf};

  pcr_tx_validity u_tx_validity (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cfg_in(val_cfg),
    .src_is_rx_in(tx_src_is_rx_in),
    .rx_validity_in(rx_validity_in),
    .tx_validity_out(tx_validity_out)
  );

endmodule // pcr_bank

// ===== pcr_pkg.sv
/*
  pcr_pkg: constants and carrier types for the pll configuration and identity register bank.
  assumes: 8-bit register addresses and data delivered by the control interface decoder.
*/
package pcr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PCR_ADDR_RESET_ID_LOW = 8'h00;
  localparam logic [7:0] PCR_ADDR_ID_HIGH = 8'h01;
  localparam logic [7:0] PCR_ADDR_REVISION = 8'h02;
  localparam logic [7:0] PCR_ADDR_FRAC_LOW = 8'h03;
  localparam logic [7:0] PCR_ADDR_FRAC_MID = 8'h04;
  localparam logic [7:0] PCR_ADDR_FRAC_HIGH = 8'h05;
  localparam logic [7:0] PCR_ADDR_INT_VALIDITY = 8'h06;
  localparam logic [7:0] PCR_ADDR_PLL_MODE = 8'h07;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PCR_FRAC_HIGH_MSB = 5;
  localparam int PCR_INT_MSB = 3;
  localparam int PCR_HALVER_BIT = 4;
  localparam int PCR_VAL_SF0_BIT = 5;
  localparam int PCR_VAL_SF1_BIT = 6;
  localparam int PCR_VAL_OVR_BIT = 7;
  localparam int PCR_FRAC_MODE_BIT = 2;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] PCR_RST_FRAC_LOW = 8'h21;
  localparam logic [7:0] PCR_RST_FRAC_MID = 8'hfd;
  localparam logic [5:0] PCR_RST_FRAC_HIGH = 6'h36;
  localparam logic [3:0] PCR_RST_INT = 4'h7;
  localparam logic PCR_RST_HALVER = 1'b0;
  localparam logic [1:0] PCR_RST_VAL_SF = 2'h0;
  localparam logic PCR_RST_VAL_OVR = 1'b0;
  localparam logic PCR_RST_FRAC_MODE = 1'b1;
  localparam logic [7:0] PCR_READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [21:0] frac;
    logic [3:0] integ;
    logic halver;
    logic [1:0] val_sf;
    logic val_ovr;
    logic frac_mode;
  } pcr_regs_t;

  localparam pcr_regs_t PCR_REGS_RESET = '{
    frac: {PCR_RST_FRAC_HIGH, PCR_RST_FRAC_MID, PCR_RST_FRAC_LOW},
    integ: PCR_RST_INT,
    halver: PCR_RST_HALVER,
    val_sf: PCR_RST_VAL_SF,
    val_ovr: PCR_RST_VAL_OVR,
    frac_mode: PCR_RST_FRAC_MODE
  };

  typedef struct packed {
    logic [21:0] frac;
    logic [3:0] integ;
    logic frac_mode;
  } pcr_ratio_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcr_req_t;

  typedef struct packed {
    logic override;
    logic [1:0] sf;
  } pcr_val_cfg_t;

endpackage

// ===== pcr_tx_validity.sv
/*
  pcr_tx_validity: chooses the validity bit per subframe for the s/pdif transmitter.
  assumes: rx validity and source select come from logic on clk_in, so no synchronisers.
*/
`timescale 1ns/10ps
module pcr_tx_validity (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // configuration
  input wire pcr_pkg::pcr_val_cfg_t cfg_in,
  // transmitter context
  input wire logic src_is_rx_in,
  input wire logic [1:0] rx_validity_in,
  // result
  output logic [1:0] tx_validity_out
);
  import pcr_pkg::*;

  typedef struct packed {
    logic [1:0] val;
  } pcr_val_state_t;

  pcr_val_state_t s_q;
  pcr_val_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (cfg_in.override) begin
      s_d.val = cfg_in.sf; // RULE_09
    end else if (src_is_rx_in) begin
      s_d.val = rx_validity_in; // RULE_08
    end else begin
      s_d.val = 2'h0; // RULE_08
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_validity_out = s_q.val;

endmodule // pcr_tx_validity

// ===== pcr_bank_monitor.sv
/* pcr_bank_monitor: assertions on the pcr_bank ports.
   assumes: bound to pcr_bank, one clock domain. */
`timescale 1ns/10ps
module pcr_bank_monitor #(
  parameter logic [15:0] ID_CODE = 16'h3c5a // arbitrary value
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire pcr_pkg::pcr_req_t req_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic device_reset_out,
  input wire pcr_pkg::pcr_ratio_t pll_ratio_out,
  input wire logic pll_input_halver_out,
  input wire logic pll_ref_en_out
);
  import pcr_pkg::*;
  logic wr0;
  logic wr6;
  assign wr0 = req_in.wr_en && req_in.addr == PCR_ADDR_RESET_ID_LOW;
  assign wr6 = req_in.wr_en && req_in.addr == PCR_ADDR_INT_VALIDITY;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_reset_pulse: assert property (wr0 |=> device_reset_out) else $error("no reset pulse");
  a_reset_cause: assert property (device_reset_out |-> $past(wr0)) else $error("stray reset");
  a_read_cause: assert property (rd_valid_out |-> $past(req_in.rd_en)) else $error("stray read valid");
  a_id_low: assert property (req_in.rd_en && req_in.addr == 8'h00 |=> rd_valid_out && rd_data_out == ID_CODE[7:0])
    else $error("id low wrong");
  a_id_high: assert property (req_in.rd_en && req_in.addr == 8'h01 |=> rd_data_out == ID_CODE[15:8])
    else $error("id high wrong");
  a_integer_write: assert property (wr6 ##1 !wr0 |=> pll_ratio_out.integ == $past(req_in.wdata[3:0], 2))
    else $error("integer ratio wrong");
  a_halver_write: assert property (wr6 |=> pll_input_halver_out == $past(req_in.wdata[4]))
    else $error("halver wrong");
  a_halver_rate: assert property (pll_input_halver_out ##1 pll_input_halver_out |-> pll_ref_en_out != $past(pll_ref_en_out))
    else $error("halved enable not alternating");
  a_full_rate: assert property (!pll_input_halver_out |-> pll_ref_en_out) else $error("enable low undivided");
  a_integer_mode: assert property (!pll_ratio_out.frac_mode |-> pll_ratio_out.frac == 22'h000000)
    else $error("fraction used in integer mode");
  a_reset_ratio: assert property (device_reset_out |=> pll_ratio_out == {22'h36fd21, 4'h7, 1'b1})
    else $error("ratio not default");
  a_reset_halver: assert property (device_reset_out |-> !pll_input_halver_out) else $error("halver kept");
  c_reset: cover property (wr0);
  c_halved: cover property (pll_input_halver_out && !pll_ref_en_out);
  c_int_mode: cover property (!pll_ratio_out.frac_mode);
endmodule // pcr_bank_monitor
bind pcr_bank pcr_bank_monitor #(.ID_CODE(ID_CODE)) u_pcr_bank_monitor (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .req_in(req_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .device_reset_out(device_reset_out),
  .pll_ratio_out(pll_ratio_out), .pll_input_halver_out(pll_input_halver_out), .pll_ref_en_out(pll_ref_en_out));

// ===== tb.sv
/* tb: self-checking bench for pcr_bank through its strobe register port.
   assumes: pcr_pkg and pcr_bank_monitor compiled first. */
`timescale 1ns/10ps
module tb;
  import pcr_pkg::*;
  localparam logic [15:0] ID = 16'h9e41; // arbitrary value
  localparam logic [3:0] REV = 4'h3; // arbitrary value
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  pcr_req_t req_in = '0;
  logic src = 1'b0;
  logic [1:0] rxv = 2'b00;
  logic [7:0] rd_data_out;
  logic rd_valid_out, device_reset_out, halver, ref_en, e;
  pcr_ratio_t ratio;
  logic [1:0] txv;
  int fail_count = 0;
  int compares = 0;
  always #4 clk_in = ~clk_in;
  pcr_bank #(.ID_CODE(ID), .REVISION(REV)) u_pcr_bank (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .device_reset_out(device_reset_out),
    .pll_ratio_out(ratio), .pll_input_halver_out(halver), .pll_ref_en_out(ref_en),
    .tx_src_is_rx_in(src), .rx_validity_in(rxv), .tx_validity_out(txv));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    req_in = '{1'b1, 1'b0, a, d};
    @(negedge clk_in);
    req_in.wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(negedge clk_in);
    req_in = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_in);
    req_in.rd_en = 1'b0;
    chk("rd_valid", 1, rd_valid_out);
    chk("rd_data", x, rd_data_out);
  endtask
  task automatic settle();
    repeat (2) @(negedge clk_in);
  endtask
  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk("ratio", {22'h36fd21, 4'h7, 1'b1}, ratio);
    chk("halver", 4'b1000, {ref_en, halver, txv});
    rd(8'h00, ID[7:0]);
    wr(8'h01, 8'h00);
    rd(8'h01, ID[15:8]);
    rd(8'h02, {4'h0, REV});
    rd(8'h03, 8'h00);
    $display("test reset_and_id done");
    wr(8'h03, 8'ha5);
    wr(8'h04, 8'h3c);
    wr(8'h05, 8'hff);
    wr(8'h06, 8'h1d);
    chk("halver", 1, halver);
    chk("dev_reset", 0, device_reset_out);
    settle();
    chk("ratio", {22'h3f3ca5, 4'hd, 1'b1}, ratio);
    e = ref_en;
    @(negedge clk_in);
    chk("ref_en", !e, ref_en);
    wr(8'h07, 8'h00);
    settle();
    chk("int_mode", {22'h0, 4'hd, 1'b0}, ratio);
    wr(8'h07, 8'h04);
    settle();
    chk("frac_mode", {22'h3f3ca5, 4'hd, 1'b1}, ratio);
    $display("test pll_ratio done");
    src = 1'b1;
    rxv = 2'b10;
    settle();
    chk("tx_val", 2'b10, txv);
    src = 1'b0;
    settle();
    chk("tx_val", 2'b00, txv);
    wr(8'h06, 8'ha7);
    settle();
    chk("tx_val", 2'b01, txv);
    src = 1'b1;
    rxv = 2'b01;
    wr(8'h06, 8'hc7);
    settle();
    chk("tx_val", 2'b10, txv);
    $display("test validity done");
    wr(8'h00, 8'h5a);
    chk("dev_reset", 1, device_reset_out);
    settle();
    chk("ratio", {22'h36fd21, 4'h7, 1'b1}, ratio);
    chk("halver_tx", 3'b001, {halver, txv});
    rd(8'h00, ID[7:0]);
    $display("test device_reset done");
    stop_test();
  end
  // the whole sequence needs well under 300 cycles
  initial begin
    #20us;
    fail_count++;
    $display("[ERR] watchdog expired");
    stop_test();
  end
endmodule // tb
